// >>> ending_pulse_sequencer.sv
// Ending pulse sequencer with AXI4-Lite control and status
// How it works
// - Ending pulse spans t6 to t5 step
// - Transfers and index ops use transfer pulse
// - Normal pulse drives three lines, transfer two
// - Acked line two clears holder, counter, stores
// - Missing operand ack suppresses clears, delays
// - Conflicts or prior faults block the ack
// - Line three calls n+2 or target
// - Modify start needs call success; call follows
// - Modify start sets modify flag for n+1
// - Line three sets end delay, execute, stall-clear
// - End delay sends end pulse to AU
// - Unacked operand call holds the pulse on
// - Held line one feeds C1+0 adder input
// - Same adder action for late long pulse
// - Noncontinuous running stops at ending pulse
// - Halt gates block call, modify; gate a blocks hold
// - Noncontinuous still clears and sets delay
// - No-overlap calls spaced twenty microseconds apart
// - Serial switch blocks calls and the modify-start call flag
// - Call success marks instruction in holder one
// - Modify start resets hold; halt gate a blocks setting
// - Serial mode sets call flag when idle
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
module ending_pulse_sequencer
  import end_pulse_pkg::*;
#(
  parameter int unsigned PHASE_LEN = PHASE_CLKS
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // AXI4-Lite slave
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [3:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // Sequencing inputs
  input  wire logic        i_instr_end,
  input  wire logic        i_transfer_kind,
  input  wire logic        i_index_return,
  input  wire logic        i_operand_ref,
  input  wire logic        i_memory_free_ack,
  input  wire logic        i_call_ack,
  input  wire logic        i_conflict_eq,
  input  wire logic        i_cond_transfer_prior,
  input  wire logic        i_prior_error,
  input  wire logic        i_result_stage,
  // Sequencing outputs
  output end_lines_s       o_end_lines,
  output logic             o_clear_second_holder,
  output logic             o_counter_clear_signal,
  output logic             o_next_call_gate,
  output logic             o_call_target,
  output logic             o_modify_start_gate,
  output logic             o_modify_flag,
  output logic             o_call_flag,
  output logic             o_completing_call_flag,
  output logic             o_adder_c1_zero,
  output logic             o_end_delay_flag,
  output logic             o_execute_stage_flag,
  output logic             o_au_end_pulse,
  output logic             o_stall_clear_pulse,
  output logic             o_stopped
);
  typedef struct packed {
    logic [3:0]  ctrl;
    logic        end_active;
    logic        transfer_mode;
    logic        ack_latch;
    logic        block_ack;
    logic        pulse_hold;
    logic        call_flag;
    logic        completing_call;
    logic        call_success;
    logic        modify_flag;
    logic        end_delay;
    logic        execute_stage;
    logic        stopped;
    logic [1:0]  ack_age;
    logic [2:0]  gap_cnt;
    logic        clear_holder;
    logic        next_call;
    logic        call_target;
    logic        modify_start;
    logic        au_end;
    logic        stall_clear;
    logic        adder_c1;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  aw_addr;
    logic [3:0]  wbits;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_s;

  state_s state_reg;
  state_s state_next;
  phase_t phase;
  logic   strobe;
  logic   halt_gate_a;
  logic   halt_gate_b;
  logic   noncont;
  logic   serial_mode_switch;

  // ************************************************************
  // Phase timing
  // ************************************************************
  phase_timer #(
    .CLKS (PHASE_LEN)
  ) u_phase (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .o_phase  (phase),
    .o_strobe (strobe)
  );

  // True on the first clock of the given phase
  function automatic logic at_phase(input phase_t ph, input phase_t cur, input logic stb);
    at_phase = stb && (cur == ph);
  endfunction

  // Console modes; gate a blocks storage, both block sequencing
  assign halt_gate_a        = state_reg.ctrl[CTRL_STOP_BIT] | state_reg.ctrl[CTRL_ONE_INSTR_BIT];
  assign halt_gate_b        = state_reg.ctrl[CTRL_MULTIVIB_BIT] | state_reg.ctrl[CTRL_ONE_INSTR_BIT];
  assign noncont            = halt_gate_a | halt_gate_b;
  assign serial_mode_switch = state_reg.ctrl[CTRL_SERIAL_BIT];

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    // Gate outputs are one-clock pulses
    state_next.clear_holder = 1'b0;
    state_next.next_call = 1'b0;
    state_next.call_target = 1'b0;
    state_next.modify_start = 1'b0;
    state_next.au_end = 1'b0;
    state_next.stall_clear = 1'b0;
    state_next.adder_c1 = 1'b0;

    // Effects of the last modify start; later phase sets override
    if (state_reg.modify_start) begin
      state_next.modify_flag = 1'b1;
      state_next.pulse_hold = 1'b0;
      state_next.call_success = 1'b0;
      if (!serial_mode_switch) begin
        state_next.call_flag = 1'b1;
      end
    end
    if (!noncont) begin
      state_next.stopped = 1'b0;
    end
    if (i_index_return) begin
      state_next.transfer_mode = 1'b0;
    end

    // t0: age of call success, no-overlap spacing
    if (at_phase(PH_T0, phase, strobe)) begin
      if (state_reg.call_success && state_reg.ack_age < 2'(LONG_ACK_CYCLES)) begin
        state_next.ack_age = state_reg.ack_age + 2'h1;
      end
      if (state_reg.gap_cnt < 3'(NO_OVERLAP_CYCLES - 1)) begin
        state_next.gap_cnt = state_reg.gap_cnt + 3'h1;
      end
      if (serial_mode_switch && !state_reg.call_success && i_result_stage && !halt_gate_b
          && state_reg.gap_cnt >= 3'(NO_OVERLAP_CYCLES - 1)) begin
        state_next.call_flag = 1'b1;
        state_next.gap_cnt = 3'h0;
      end
    end

    // t1: operand memory-free acknowledge, unless blocked
    if (at_phase(PH_T1, phase, strobe)) begin
      state_next.ack_latch = !state_reg.block_ack && (!i_operand_ref || i_memory_free_ack);
    end

    // t2: instruction lands in holder one; stored pulse replays
    if (at_phase(PH_T2, phase, strobe)) begin
      if (state_reg.completing_call) begin
        state_next.call_success = 1'b1;
        state_next.completing_call = 1'b0;
        state_next.ack_age = 2'h0;
      end
      if (state_reg.pulse_hold && state_reg.call_success && !noncont) begin
        state_next.modify_start = 1'b1;
        state_next.next_call = !serial_mode_switch;
      end
    end

    // t3 and t7: index conflict blocks the ack; prior faults block it at t7 only
    if (at_phase(PH_T3, phase, strobe) || at_phase(PH_T7, phase, strobe)) begin
      if (state_reg.modify_flag && i_conflict_eq) begin
        state_next.block_ack = 1'b1;
      end
    end
    if (at_phase(PH_T7, phase, strobe) && (i_cond_transfer_prior || i_prior_error)) begin
      state_next.block_ack = 1'b1;
    end
    if (at_phase(PH_T4, phase, strobe) && !state_reg.modify_start) begin
      state_next.modify_flag = 1'b0;
    end

    // t5: call acknowledge and the end of the ending pulse
    if (at_phase(PH_T5, phase, strobe)) begin
      if (state_reg.call_flag && i_call_ack) begin
        state_next.completing_call = 1'b1;
        state_next.call_flag = 1'b0;
      end
      if (state_reg.end_active && !state_reg.transfer_mode && !state_reg.completing_call
          && state_reg.call_success && state_reg.ack_age >= 2'(LONG_ACK_CYCLES)) begin
        state_next.adder_c1 = 1'b1;
      end
      if (state_reg.end_active) begin
        if (state_reg.ack_latch) begin
          state_next.end_active = 1'b0;
          state_next.clear_holder = 1'b1;
          state_next.end_delay = 1'b1;
          state_next.block_ack = 1'b0;
          if (!state_reg.call_success && !halt_gate_a) begin
            state_next.pulse_hold = 1'b1;
          end
          if (!noncont && !serial_mode_switch) begin
            state_next.next_call = 1'b1;
            state_next.call_target = state_reg.transfer_mode;
          end
          if (state_reg.call_success && !noncont) begin
            state_next.modify_start = 1'b1;
          end
          if (noncont) begin
            state_next.stopped = 1'b1;
          end
        end else if (i_operand_ref) begin
          state_next.end_active = 1'b1;
        end else begin
          // Blocked pulse ends with no functions
          state_next.end_active = 1'b0;
          state_next.block_ack = 1'b0;
        end
      end
    end

    // t6: new program-counter step; delayed end goes to the AU
    if (at_phase(PH_T6, phase, strobe)) begin
      state_next.execute_stage = state_reg.end_delay;
      if (state_reg.end_delay) begin
        state_next.au_end = 1'b1;
        state_next.stall_clear = 1'b1;
        state_next.end_delay = 1'b0;
      end
      if (!state_reg.end_active && i_instr_end && !state_reg.stopped) begin
        state_next.end_active = 1'b1;
        state_next.transfer_mode = i_transfer_kind;
      end
    end

    // ************************************************************
    // AXI4-Lite slave: address and data taken in either order
    // ************************************************************
    if (i_awvalid && o_awready) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      state_next.w_got = 1'b1;
      state_next.wbits = i_wstrb[0] ? i_wdata[3:0] : state_reg.ctrl;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      if (state_reg.aw_addr == CTRL_OFFSET) begin
        state_next.ctrl = state_reg.wbits;
      end else if (state_reg.aw_addr != STATUS_OFFSET) begin
        state_next.bresp = RESP_SLVERR;
      end
    end
    if (state_reg.bvalid && i_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      state_next.rdata = 32'h0;
      if (i_araddr == CTRL_OFFSET) begin
        state_next.rdata = {28'h0, state_reg.ctrl};
      end else if (i_araddr == STATUS_OFFSET) begin
        state_next.rdata = {20'h0, state_reg.stopped, state_reg.execute_stage, state_reg.end_delay,
                            state_reg.modify_flag, state_reg.call_success, state_reg.completing_call,
                            state_reg.call_flag, state_reg.pulse_hold, state_reg.block_ack,
                            state_reg.ack_latch, state_reg.transfer_mode, state_reg.end_active};
      end else begin
        state_next.rresp = RESP_SLVERR;
      end
    end else if (state_reg.rvalid && i_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_reg <= '0;
      state_reg.ctrl <= CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_awready = !state_reg.aw_got && !state_reg.bvalid;
  assign o_wready  = !state_reg.w_got && !state_reg.bvalid;
  assign o_bvalid  = state_reg.bvalid;
  assign o_bresp   = state_reg.bresp;
  assign o_arready = !state_reg.rvalid;
  assign o_rvalid  = state_reg.rvalid;
  assign o_rdata   = state_reg.rdata;
  assign o_rresp   = state_reg.rresp;

  // Transfer pulse never drives line one
  assign o_end_lines.one   = state_reg.end_active && !state_reg.transfer_mode;
  assign o_end_lines.two   = state_reg.end_active;
  assign o_end_lines.three = state_reg.end_active;

  assign o_clear_second_holder  = state_reg.clear_holder;
  assign o_counter_clear_signal = state_reg.clear_holder;
  assign o_next_call_gate       = state_reg.next_call;
  assign o_call_target          = state_reg.call_target;
  assign o_modify_start_gate    = state_reg.modify_start;
  assign o_modify_flag          = state_reg.modify_flag;
  assign o_call_flag            = state_reg.call_flag;
  assign o_completing_call_flag = state_reg.completing_call;
  assign o_adder_c1_zero        = state_reg.adder_c1;
  assign o_end_delay_flag       = state_reg.end_delay;
  assign o_execute_stage_flag   = state_reg.execute_stage;
  assign o_au_end_pulse         = state_reg.au_end;
  assign o_stall_clear_pulse    = state_reg.stall_clear;
  assign o_stopped              = state_reg.stopped;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  line_fanout_a: assert property (o_end_lines.one |-> o_end_lines.two && o_end_lines.three)
    else $error("line one without lines two and three");
  transfer_lines_a: assert property (state_reg.end_active && state_reg.transfer_mode |-> !o_end_lines.one)
    else $error("transfer pulse drove line one");
  clear_needs_ack_a: assert property (o_clear_second_holder |-> $past(state_reg.ack_latch) && $past(state_reg.end_active))
    else $error("holder cleared without operand ack");
  held_pulse_a: assert property (at_phase(PH_T5, phase, strobe) && state_reg.end_active && !state_reg.ack_latch
                                 && i_operand_ref |=> state_reg.end_active && !o_clear_second_holder)
    else $error("unacked operand pulse not held");
  modify_sets_a: assert property (o_modify_start_gate |=> o_modify_flag)
    else $error("modify start did not set modify flag");
  modify_success_a: assert property (o_modify_start_gate |-> $past(state_reg.call_success))
    else $error("modify start without call success");
  delay_with_clear_a: assert property (o_clear_second_holder |-> o_end_delay_flag)
    else $error("end delay not set with clear");
  au_end_pair_a: assert property (o_au_end_pulse |-> o_stall_clear_pulse && o_execute_stage_flag ##1 !o_au_end_pulse)
    else $error("au end pulse malformed");
  halt_block_a: assert property (o_next_call_gate || o_modify_start_gate |-> !$past(noncont))
    else $error("call or modify while halted");
  serial_block_a: assert property (o_next_call_gate |-> !$past(serial_mode_switch))
    else $error("ending pulse call in serial mode");
  phase_step_a: assert property (strobe |-> phase == 3'($past(phase) + 3'h1))
    else $error("phase did not advance by one");

  normal_end_c: cover property (o_clear_second_holder && o_modify_start_gate);
  held_pulse_c: cover property (state_reg.end_active && !state_reg.ack_latch && at_phase(PH_T5, phase, strobe));
  serial_call_c: cover property (serial_mode_switch && o_call_flag);
  stop_c: cover property (o_stopped && o_au_end_pulse);
endmodule
`default_nettype wire

// >>> end_pulse_pkg.sv
// Shared constants and carrier types for the ending pulse sequencer
`default_nettype none
package end_pulse_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLOCK_PERIOD_NS   = 4;
  localparam int CONTROL_CYCLE_NS  = 4000;
  localparam int PHASE_COUNT       = 8;
  localparam int PHASE_CLKS        = CONTROL_CYCLE_NS / (CLOCK_PERIOD_NS * PHASE_COUNT);
  localparam int NO_OVERLAP_NS     = 20000;
  localparam int NO_OVERLAP_CYCLES = NO_OVERLAP_NS / CONTROL_CYCLE_NS;
  localparam int LONG_ACK_CYCLES   = 2;

  typedef logic [2:0] phase_t;
  localparam phase_t PH_T0 = 3'h0;
  localparam phase_t PH_T1 = 3'h1;
  localparam phase_t PH_T2 = 3'h2;
  localparam phase_t PH_T3 = 3'h3;
  localparam phase_t PH_T4 = 3'h4;
  localparam phase_t PH_T5 = 3'h5;
  localparam phase_t PH_T6 = 3'h6;
  localparam phase_t PH_T7 = 3'h7;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam int CTRL_STOP_BIT       = 0;
  localparam int CTRL_MULTIVIB_BIT   = 1;
  localparam int CTRL_ONE_INSTR_BIT  = 2;
  localparam int CTRL_SERIAL_BIT     = 3;
  localparam logic [3:0] CTRL_RESET  = 4'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // The three fan-out lines of one ending pulse
  typedef struct packed {
    logic one;
    logic two;
    logic three;
  } end_lines_s;
endpackage
`default_nettype wire

// >>> phase_timer.sv
// Phase generator: eight phases t0..t7 per control cycle
`default_nettype none
module phase_timer
  import end_pulse_pkg::*;
#(
  parameter int unsigned CLKS = PHASE_CLKS
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  output phase_t    o_phase,
  output logic      o_strobe
);
  typedef struct packed {
    logic [$clog2(CLKS)-1:0] cnt;
    phase_t                  phase;
    logic                    strobe;
  } timer_s;

  timer_s state_reg;
  timer_s state_next;

  // Strobe marks the first clock of the phase now shown
  always_comb begin
    state_next = state_reg;
    state_next.strobe = 1'b0;
    if (state_reg.cnt == ($clog2(CLKS))'(CLKS - 1)) begin
      state_next.cnt = '0;
      state_next.phase = state_reg.phase + 3'h1;
      state_next.strobe = 1'b1;
    end else begin
      state_next.cnt = state_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_phase  = state_reg.phase;
  assign o_strobe = state_reg.strobe;
endmodule
`default_nettype wire

// >>> au_memory_model.sv
// Far-side model: arithmetic unit and memory call logic
`default_nettype none
module au_memory_model (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_busy,
  input  wire logic i_call_flag,
  input  wire logic i_au_end_pulse,
  output logic      o_memory_free_ack,
  output logic      o_call_ack,
  output logic      o_index_return
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Responses
  // ****
  // Registered, so every answer trails its cause by one clock
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_memory_free_ack <= 1'b0;
      o_call_ack        <= 1'b0;
      o_index_return    <= 1'b0;
    end else begin
      o_memory_free_ack <= !i_busy;
      o_call_ack        <= i_call_flag && !i_busy;
      // Decoder cleared by the end pulse, then back to main program
      o_index_return    <= i_au_end_pulse;
    end
  end
endmodule
`default_nettype wire

// >>> tb_ending_pulse_sequencer.sv
// Self-checking bench for the ending pulse sequencer
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t got %0h exp %0h", $time, g, e); end end
module tb_ending_pulse_sequencer
  import end_pulse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PHASE = 4;
  localparam logic KINDS [8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam logic [3:0] CTRLS [8] = '{4'h0, 4'h0, 4'h1, 4'h4, 4'h2, 4'h8, 4'h0, 4'h0};
  localparam logic STALLS [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  // Last entry raises a prior fault, so the operand ack is blocked
  localparam logic BLOCKS [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic        clock = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        instr_end = 0, transfer_kind = 0, result_stage = 0, busy = 0, operand_ref = 0, fault = 0;
  logic        end_delay, exec_stage;
  logic        awready, wready, bvalid, arready, rvalid, mem_ack, call_ack, index_return;
  logic [1:0]  bresp, rresp;
  end_lines_s  end_lines;
  logic        clear_holder, counter_clear, next_call, call_target, call_flag, au_end, stall_clear, stopped;
  int          error_cnt = 0, comparisons = 0, run_len = 0, pulse_len = 0;
  int          cnt [4];

  always #2 clock = ~clock;

  ending_pulse_sequencer #(.PHASE_LEN(PHASE)) dut_u (
    .i_clock(clock), .i_rst_n(rst_n), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_instr_end(instr_end),
    .i_transfer_kind(transfer_kind), .i_index_return(index_return), .i_operand_ref(operand_ref),
    .i_memory_free_ack(mem_ack), .i_call_ack(call_ack), .i_conflict_eq(1'b0),
    .i_cond_transfer_prior(1'b0), .i_prior_error(fault), .i_result_stage(result_stage),
    .o_end_lines(end_lines), .o_clear_second_holder(clear_holder), .o_counter_clear_signal(counter_clear),
    .o_next_call_gate(next_call), .o_call_target(call_target), .o_modify_start_gate(), .o_modify_flag(),
    .o_call_flag(call_flag), .o_completing_call_flag(), .o_adder_c1_zero(), .o_end_delay_flag(end_delay),
    .o_execute_stage_flag(exec_stage), .o_au_end_pulse(au_end), .o_stall_clear_pulse(stall_clear),
    .o_stopped(stopped));

  au_memory_model partner_u (
    .i_clock(clock), .i_rst_n(rst_n), .i_busy(busy), .i_call_flag(call_flag), .i_au_end_pulse(au_end),
    .o_memory_free_ack(mem_ack), .o_call_ack(call_ack), .o_index_return(index_return));

  // ****
  // Monitors and closing
  // ****
  // Length of the last ending pulse, in clocks
  always @(negedge clock) begin
    if (end_lines != 3'h0) run_len++;
    else if (run_len != 0) begin
      pulse_len = run_len;
      run_len = 0;
    end
  end

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic give_up();
    error_cnt++;
    tally_and_finish();
  endtask

  // Counts one-clock pulses; sampled mid-cycle where outputs are settled
  // Returns mid-cycle, so callers wait for a rising edge before driving
  task automatic watch(input int len);
    cnt = '{default: 0};
    repeat (len) begin
      @(negedge clock);
      cnt[0] += int'(clear_holder === 1'b1 && counter_clear === 1'b1 && end_delay === 1'b1);
      cnt[1] += int'(next_call === 1'b1 || call_target === 1'b1);
      cnt[2] += int'(au_end === 1'b1 && exec_stage === 1'b1);
      cnt[3] += int'(stall_clear === 1'b1);
    end
  endtask

  // ****
  // Register bus
  // ****
  task automatic axi_write(input logic [3:0] addr, input logic [31:0] data, input logic [1:0] exp_r);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    @(posedge clock);
    awaddr <= addr;
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    if (n == 100) give_up();
    `CHK(r, exp_r)
  endtask

  task automatic axi_read(input logic [3:0] addr, input logic [31:0] exp_d, input logic [1:0] exp_r);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge clock);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge clock);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      if (tr) break;
    end
    rready <= 1'b0;
    if (n == 100) give_up();
    `CHK(d, exp_d)
    `CHK(r, exp_r)
  endtask

  // ****
  // Ending pulse scenario with its expected outcome
  // ****
  task automatic run_pulse(input logic kind, input logic [3:0] ctrl, input logic stall, input logic block);
    int n;
    @(posedge clock);
    transfer_kind <= kind;
    busy <= stall;
    fault <= block;
    // A blocked pulse without operand reference must end, not hang
    operand_ref <= stall ? 1'b1 : (block ? 1'b0 : 1'($urandom));
    result_stage <= 1'($urandom);
    instr_end <= 1'b1;
    for (n = 0; n < 64 && end_lines === 3'h0; n++) @(negedge clock);
    if (n == 64) give_up();
    `CHK(end_lines, kind ? 3'h3 : 3'h7)
    @(posedge clock);
    instr_end <= 1'b0;
    watch(40);
    `CHK(cnt[0], (stall || block) ? 0 : 1)
    `CHK(cnt[1], (stall || block || ctrl != 4'h0) ? 0 : 1)
    `CHK(cnt[2], (stall || block) ? 0 : 1)
    `CHK(cnt[3], (stall || block) ? 0 : 1)
    `CHK(stopped, ctrl[2:0] != 3'h0)
    if (block) `CHK(cnt[0] + cnt[1], 0)
    if (stall) begin
      `CHK(end_lines === 3'h0, 1'b0)
      @(posedge clock);
      busy <= 1'b0;
      watch(64);
      `CHK(cnt[0], 1)
    end else begin
      `CHK(pulse_len, 7 * PHASE)
    end
  endtask

  // ****
  // Main sequence
  // ****
  // Halt and serial modes ride along in the table, with bus noise in upper bits
  initial begin
    void'($urandom(10647));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    axi_read(4'h8, 32'h0, RESP_SLVERR);
    axi_write(4'hC, 32'h1, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      axi_write(CTRL_OFFSET, {28'($urandom), CTRLS[i]}, RESP_OKAY);
      axi_read(CTRL_OFFSET, {28'h0, CTRLS[i]}, RESP_OKAY);
      run_pulse(KINDS[i], CTRLS[i], STALLS[i], BLOCKS[i]);
      axi_write(CTRL_OFFSET, 32'h0, RESP_OKAY);
      watch(60);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
